//--- inc/uisd_defs.svh
// register offsets, field positions and reset values for the uart irq/dma control block
`ifndef UISD_DEFS_SVH
`define UISD_DEFS_SVH

// byte offsets of the registers
`define UISD_OFS_MASK        8'h38
`define UISD_OFS_RAW         8'h3c
`define UISD_OFS_MASKED      8'h40
`define UISD_OFS_CLEAR       8'h44
`define UISD_OFS_DMA         8'h48

// pending, mask and clear bit positions (shared layout)
`define UISD_BIT_CTS         1
`define UISD_BIT_RX          4
`define UISD_BIT_TX          5
`define UISD_BIT_RXTO        6
`define UISD_BIT_FRAME       7
`define UISD_BIT_PARITY      8
`define UISD_BIT_BREAK       9
`define UISD_BIT_OVERRUN     10
`define UISD_BIT_FLOWSTOP    11
`define UISD_BIT_TXEMPTY     12

// dma control bit positions
`define UISD_BIT_RXDMA       0
`define UISD_BIT_TXDMA       1
`define UISD_BIT_DMAHALT     3

// reset values
`define UISD_RST_FLAGS       10'h000
`define UISD_RST_MASK        10'h000
`define UISD_RST_DMA         3'h0
`define UISD_RST_RDATA       32'h0000_0000

`endif

//--- inc/uisd_pkg.sv
// types of the uart irq/dma control block
package uisd_pkg;

    // number of interrupt sources
    localparam int UISD_NSRC = 10;

    // compact source vector, index order cts, rx, tx, rxto, frame, parity, break, overrun, flowstop, txempty
    typedef logic [UISD_NSRC-1:0] uisd_src_vec_t;

    // register select decoded from the bus address
    typedef enum logic [2:0] {
        UISD_SEL_NONE   = 3'b000,
        UISD_SEL_MASK   = 3'b001,
        UISD_SEL_RAW    = 3'b010,
        UISD_SEL_MASKED = 3'b011,
        UISD_SEL_CLEAR  = 3'b100,
        UISD_SEL_DMA    = 3'b101
    } uisd_sel_t;

endpackage : uisd_pkg

//--- hw/uisd_flag_bank.sv
// bank of sticky pending flags, set by events and cleared by software
`timescale 1ns/1ps
module uisd_flag_bank #(
    parameter int N = 10
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_b,
    input  wire logic [N-1:0] i_set,
    input  wire logic [N-1:0] i_clr,
    output logic      [N-1:0] o_flags
);

    logic [N-1:0] flags_r;
    logic [N-1:0] flags_nxt;

    // per flag: event set beats a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            assign flags_nxt[g] = i_set[g] | (flags_r[g] & ~i_clr[g]);
        end
    endgenerate

    // flag storage, zero after reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign o_flags = flags_r;

endmodule : uisd_flag_bank

//--- hw/uisd_top.sv
// uart interrupt status, mask, clear and dma request control
`timescale 1ns/1ps
`include "uisd_defs.svh"
module uisd_top
    import uisd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_b,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    output logic      [31:0]       o_rdata,
    // one-cycle event pulses from the rest of the port
    input  wire logic              i_cts_evt,
    input  wire logic              i_rx_evt,
    input  wire logic              i_tx_evt,
    input  wire logic              i_rx_timeout_evt,
    input  wire logic              i_framing_err_evt,
    input  wire logic              i_parity_err_evt,
    input  wire logic              i_break_err_evt,
    input  wire logic              i_overrun_err_evt,
    input  wire logic              i_flow_stop_evt,
    input  wire logic              i_tx_queue_empty_evt,
    // dma readiness from the data path
    input  wire logic              i_rx_data_avail,
    input  wire logic              i_tx_space_avail,
    // interrupt and dma requests
    output logic                   o_irq,
    output logic                   o_rx_dma_req,
    output logic                   o_tx_dma_req,
    // masked flags to the rest of the port
    output logic                   o_cts_masked_flag,
    output logic                   o_receive_masked_flag,
    output logic                   o_transmit_masked_flag,
    output logic                   o_rx_timeout_masked_flag,
    output logic                   o_framing_err_masked_flag,
    output logic                   o_parity_err_masked_flag,
    output logic                   o_break_err_masked_flag,
    output logic                   o_overrun_err_masked_flag,
    output logic                   o_flow_stop_masked_flag,
    output logic                   o_tx_queue_empty_masked_flag
);

    // spread a compact source vector onto the 32-bit register layout
    function automatic logic [31:0] uisd_to_reg(input uisd_src_vec_t v);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[`UISD_BIT_CTS]      = v[0];
        r[`UISD_BIT_RX]       = v[1];
        r[`UISD_BIT_TX]       = v[2];
        r[`UISD_BIT_RXTO]     = v[3];
        r[`UISD_BIT_FRAME]    = v[4];
        r[`UISD_BIT_PARITY]   = v[5];
        r[`UISD_BIT_BREAK]    = v[6];
        r[`UISD_BIT_OVERRUN]  = v[7];
        r[`UISD_BIT_FLOWSTOP] = v[8];
        r[`UISD_BIT_TXEMPTY]  = v[9];
        return r;
    endfunction : uisd_to_reg

    // gather the source bits out of a 32-bit register word
    function automatic uisd_src_vec_t uisd_from_reg(input logic [31:0] r);
        uisd_src_vec_t v;
        v    = '0;
        v[0] = r[`UISD_BIT_CTS];
        v[1] = r[`UISD_BIT_RX];
        v[2] = r[`UISD_BIT_TX];
        v[3] = r[`UISD_BIT_RXTO];
        v[4] = r[`UISD_BIT_FRAME];
        v[5] = r[`UISD_BIT_PARITY];
        v[6] = r[`UISD_BIT_BREAK];
        v[7] = r[`UISD_BIT_OVERRUN];
        v[8] = r[`UISD_BIT_FLOWSTOP];
        v[9] = r[`UISD_BIT_TXEMPTY];
        return v;
    endfunction : uisd_from_reg

    uisd_sel_t     sel;
    uisd_src_vec_t evt_vec;
    uisd_src_vec_t raw_flags;
    uisd_src_vec_t masked_flags;
    uisd_src_vec_t mask_r;
    uisd_src_vec_t mask_nxt;
    uisd_src_vec_t clr_vec;
    logic [2:0]    dma_r;
    logic [2:0]    dma_nxt;
    logic [31:0]   rdata_r;
    logic [31:0]   rdata_nxt;
    logic [31:0]   rd_val;
    logic [31:0]   dma_word;
    logic          wr_mask;
    logic          wr_clear;
    logic          wr_dma;
    logic          rx_dma_en;
    logic          tx_dma_en;
    logic          dma_halt_en;
    logic          err_asserted;
    logic          rx_dma_blocked;
    logic [31:0]   mask_word;
    logic [31:0]   raw_word;
    logic [31:0]   masked_word;

    // per-source signals under their field names
    logic          cts_raw_flag;
    logic          receive_raw_flag;
    logic          transmit_raw_flag;
    logic          rx_timeout_raw_flag;
    logic          framing_err_raw_flag;
    logic          parity_err_raw_flag;
    logic          break_err_raw_flag;
    logic          overrun_err_raw_flag;
    logic          flow_stop_raw_flag;
    logic          tx_queue_empty_raw_flag;
    logic          cts_masked_flag;
    logic          receive_masked_flag;
    logic          transmit_masked_flag;
    logic          rx_timeout_masked_flag;
    logic          framing_err_masked_flag;
    logic          parity_err_masked_flag;
    logic          break_err_masked_flag;
    logic          overrun_err_masked_flag;
    logic          flow_stop_masked_flag;
    logic          tx_queue_empty_masked_flag;
    logic          cts_flag_clear;
    logic          receive_flag_clear;
    logic          transmit_flag_clear;
    logic          rx_timeout_flag_clear;
    logic          framing_err_flag_clear;
    logic          parity_err_flag_clear;
    logic          break_err_flag_clear;
    logic          overrun_err_flag_clear;
    logic          flow_stop_flag_clear;
    logic          tx_queue_empty_flag_clear;
    logic          cts_irq_enable_bit;
    logic          receive_irq_enable_bit;
    logic          transmit_irq_enable_bit;
    logic          rx_timeout_irq_enable_bit;
    logic          framing_err_irq_enable_bit;
    logic          parity_err_irq_enable_bit;
    logic          break_err_irq_enable_bit;
    logic          overrun_err_irq_enable_bit;
    logic          flow_stop_irq_enable_bit;
    logic          tx_queue_empty_irq_enable_bit;

    // address decode, unmapped offsets select nothing
    assign sel = (i_addr == `UISD_OFS_MASK)   ? UISD_SEL_MASK   :
                 (i_addr == `UISD_OFS_RAW)    ? UISD_SEL_RAW    :
                 (i_addr == `UISD_OFS_MASKED) ? UISD_SEL_MASKED :
                 (i_addr == `UISD_OFS_CLEAR)  ? UISD_SEL_CLEAR  :
                 (i_addr == `UISD_OFS_DMA)    ? UISD_SEL_DMA    :
                                                UISD_SEL_NONE;

    // write strobes per register; raw and masked have none
    assign wr_mask  = i_wr_stb & (sel == UISD_SEL_MASK);
    assign wr_clear = i_wr_stb & (sel == UISD_SEL_CLEAR);
    assign wr_dma   = i_wr_stb & (sel == UISD_SEL_DMA);

    // event pulses in source order
    assign evt_vec = {i_tx_queue_empty_evt, i_flow_stop_evt, i_overrun_err_evt, i_break_err_evt,
                      i_parity_err_evt, i_framing_err_evt, i_rx_timeout_evt, i_tx_evt,
                      i_rx_evt, i_cts_evt};

    // ones written to the clear register, zeros leave flags alone
    assign cts_flag_clear            = wr_clear & i_wdata[`UISD_BIT_CTS];
    assign receive_flag_clear        = wr_clear & i_wdata[`UISD_BIT_RX];
    assign transmit_flag_clear       = wr_clear & i_wdata[`UISD_BIT_TX];
    assign rx_timeout_flag_clear     = wr_clear & i_wdata[`UISD_BIT_RXTO];
    assign framing_err_flag_clear    = wr_clear & i_wdata[`UISD_BIT_FRAME];
    assign parity_err_flag_clear     = wr_clear & i_wdata[`UISD_BIT_PARITY];
    assign break_err_flag_clear      = wr_clear & i_wdata[`UISD_BIT_BREAK];
    assign overrun_err_flag_clear    = wr_clear & i_wdata[`UISD_BIT_OVERRUN];
    assign flow_stop_flag_clear      = wr_clear & i_wdata[`UISD_BIT_FLOWSTOP];
    assign tx_queue_empty_flag_clear = wr_clear & i_wdata[`UISD_BIT_TXEMPTY];
    assign clr_vec = {tx_queue_empty_flag_clear, flow_stop_flag_clear, overrun_err_flag_clear,
                      break_err_flag_clear, parity_err_flag_clear, framing_err_flag_clear,
                      rx_timeout_flag_clear, transmit_flag_clear, receive_flag_clear, cts_flag_clear};

    // sticky raw pending flags
    uisd_flag_bank #(
        .N (UISD_NSRC)
    ) u_flags (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_set      (evt_vec),
        .i_clr      (clr_vec),
        .o_flags    (raw_flags)
    );

    // mask and dma control next values
    assign mask_nxt = wr_mask ? uisd_from_reg(i_wdata) : mask_r;
    assign dma_nxt  = wr_dma ? {i_wdata[`UISD_BIT_DMAHALT], i_wdata[`UISD_BIT_TXDMA], i_wdata[`UISD_BIT_RXDMA]}
                             : dma_r;

    // software-written control registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            mask_r <= `UISD_RST_MASK;
            dma_r  <= `UISD_RST_DMA;
        end else begin
            mask_r <= mask_nxt;
            dma_r  <= dma_nxt;
        end
    end

    // mask enable bit per source
    assign cts_irq_enable_bit            = mask_r[0];
    assign receive_irq_enable_bit        = mask_r[1];
    assign transmit_irq_enable_bit       = mask_r[2];
    assign rx_timeout_irq_enable_bit     = mask_r[3];
    assign framing_err_irq_enable_bit    = mask_r[4];
    assign parity_err_irq_enable_bit     = mask_r[5];
    assign break_err_irq_enable_bit      = mask_r[6];
    assign overrun_err_irq_enable_bit    = mask_r[7];
    assign flow_stop_irq_enable_bit      = mask_r[8];
    assign tx_queue_empty_irq_enable_bit = mask_r[9];

    // raw flags under their field names
    assign cts_raw_flag            = raw_flags[0];
    assign receive_raw_flag        = raw_flags[1];
    assign transmit_raw_flag       = raw_flags[2];
    assign rx_timeout_raw_flag     = raw_flags[3];
    assign framing_err_raw_flag    = raw_flags[4];
    assign parity_err_raw_flag     = raw_flags[5];
    assign break_err_raw_flag      = raw_flags[6];
    assign overrun_err_raw_flag    = raw_flags[7];
    assign flow_stop_raw_flag      = raw_flags[8];
    assign tx_queue_empty_raw_flag = raw_flags[9];

    // masked view, same positions as raw
    assign cts_masked_flag            = cts_raw_flag & cts_irq_enable_bit;
    assign receive_masked_flag        = receive_raw_flag & receive_irq_enable_bit;
    assign transmit_masked_flag       = transmit_raw_flag & transmit_irq_enable_bit;
    assign rx_timeout_masked_flag     = rx_timeout_raw_flag & rx_timeout_irq_enable_bit;
    assign framing_err_masked_flag    = framing_err_raw_flag & framing_err_irq_enable_bit;
    assign parity_err_masked_flag     = parity_err_raw_flag & parity_err_irq_enable_bit;
    assign break_err_masked_flag      = break_err_raw_flag & break_err_irq_enable_bit;
    assign overrun_err_masked_flag    = overrun_err_raw_flag & overrun_err_irq_enable_bit;
    assign flow_stop_masked_flag      = flow_stop_raw_flag & flow_stop_irq_enable_bit;
    assign tx_queue_empty_masked_flag = tx_queue_empty_raw_flag & tx_queue_empty_irq_enable_bit;
    assign masked_flags = {tx_queue_empty_masked_flag, flow_stop_masked_flag, overrun_err_masked_flag,
                           break_err_masked_flag, parity_err_masked_flag, framing_err_masked_flag,
                           rx_timeout_masked_flag, transmit_masked_flag, receive_masked_flag,
                           cts_masked_flag};

    // single level interrupt
    assign o_irq = |masked_flags;

    // dma control fields
    assign rx_dma_en   = dma_r[0];
    assign tx_dma_en   = dma_r[1];
    assign dma_halt_en = dma_r[2];
    assign dma_word    = {28'h000_0000, dma_halt_en, 1'b0, tx_dma_en, rx_dma_en};

    // receive dma blocked while a masked error interrupt stands
    assign err_asserted   = framing_err_masked_flag | parity_err_masked_flag | break_err_masked_flag |
                            overrun_err_masked_flag;
    assign rx_dma_blocked = dma_halt_en & err_asserted;

    // dma requests to the controller
    assign o_rx_dma_req = rx_dma_en & i_rx_data_avail & ~rx_dma_blocked;
    assign o_tx_dma_req = tx_dma_en & i_tx_space_avail;

    // register words on the bus layout
    assign mask_word   = uisd_to_reg(mask_r);
    assign raw_word    = uisd_to_reg(raw_flags);
    assign masked_word = uisd_to_reg(masked_flags);

    // read mux; clear register is write-only and reads zero
    assign rd_val = (sel == UISD_SEL_MASK)   ? mask_word   :
                    (sel == UISD_SEL_RAW)    ? raw_word    :
                    (sel == UISD_SEL_MASKED) ? masked_word :
                    (sel == UISD_SEL_DMA)    ? dma_word    :
                                               32'h0000_0000;

    // read data stand only in the cycle after the strobe
    assign rdata_nxt = i_rd_stb ? rd_val : 32'h0000_0000;

    // read data register
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            rdata_r <= `UISD_RST_RDATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // per-source masked flags to the rest of the port
    assign o_cts_masked_flag            = cts_masked_flag;
    assign o_receive_masked_flag        = receive_masked_flag;
    assign o_transmit_masked_flag       = transmit_masked_flag;
    assign o_rx_timeout_masked_flag     = rx_timeout_masked_flag;
    assign o_framing_err_masked_flag    = framing_err_masked_flag;
    assign o_parity_err_masked_flag     = parity_err_masked_flag;
    assign o_break_err_masked_flag      = break_err_masked_flag;
    assign o_overrun_err_masked_flag    = overrun_err_masked_flag;
    assign o_flow_stop_masked_flag      = flow_stop_masked_flag;
    assign o_tx_queue_empty_masked_flag = tx_queue_empty_masked_flag;

endmodule : uisd_top

//--- sim/uisd_evt_model.sv
// event source standing in for the serial data path
`timescale 1ns/1ps
module uisd_evt_model
    import uisd_pkg::*;
(
    input  wire logic          i_core_clk,
    input  wire uisd_src_vec_t i_fire,
    output uisd_src_vec_t      o_evt
);
    // one-cycle event pulse one cycle after each request
    initial o_evt = '0;
    always @(posedge i_core_clk) begin
        o_evt <= i_fire;
    end
endmodule : uisd_evt_model

//--- sim/uisd_top_asserts.sv
// concurrent checks on the irq/dma control block ports
`timescale 1ns/1ps
`include "uisd_defs.svh"
module uisd_top_asserts #(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_b,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    input  wire logic [31:0]       o_rdata,
    input  wire logic              i_cts_evt,
    input  wire logic              i_rx_evt,
    input  wire logic              i_rx_data_avail,
    input  wire logic              i_tx_space_avail,
    input  wire logic              o_irq,
    input  wire logic              o_rx_dma_req,
    input  wire logic              o_tx_dma_req,
    input  wire logic              o_cts_masked_flag,
    input  wire logic              o_receive_masked_flag
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // clear write with a given bit set
    sequence s_clr(b);
        i_wr_stb && i_addr == `UISD_OFS_CLEAR && i_wdata[b];
    endsequence
    AST_RST: assert property (!$past(i_rst_b) |-> !o_irq && !o_rx_dma_req && !o_tx_dma_req)
        else $error("outputs not zero after reset");
    AST_RDATA_IDLE: assert property (!$past(i_rd_stb) || $past(i_addr) == `UISD_OFS_CLEAR |-> o_rdata == 32'h0)
        else $error("read data not zero");
    AST_RX_CLR: assert property (s_clr(4) ##0 !i_rx_evt |=> !o_receive_masked_flag)
        else $error("rx flag not cleared");
    AST_CTS_CLR: assert property (s_clr(1) ##0 !i_cts_evt |=> !o_cts_masked_flag)
        else $error("cts flag not cleared");
    AST_RX_HOLD: assert property (o_receive_masked_flag && !i_wr_stb |=> o_receive_masked_flag)
        else $error("rx flag dropped without write");
    AST_RX_RISE: assert property ($rose(o_receive_masked_flag) |-> $past(i_rx_evt) || $past(i_wr_stb))
        else $error("rx flag rose without cause");
    AST_IRQ: assert property (o_receive_masked_flag || o_cts_masked_flag |-> o_irq)
        else $error("irq low with masked flag set");
    AST_RXDMA: assert property (o_rx_dma_req |-> i_rx_data_avail)
        else $error("rx dma without data");
    AST_TXDMA: assert property (o_tx_dma_req |-> i_tx_space_avail)
        else $error("tx dma without space");
endmodule : uisd_top_asserts
bind uisd_top uisd_top_asserts #(.ADDR_W(ADDR_W)) u_chk (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .i_cts_evt(i_cts_evt),
    .i_rx_evt(i_rx_evt), .i_rx_data_avail(i_rx_data_avail), .i_tx_space_avail(i_tx_space_avail),
    .o_irq(o_irq), .o_rx_dma_req(o_rx_dma_req), .o_tx_dma_req(o_tx_dma_req),
    .o_cts_masked_flag(o_cts_masked_flag), .o_receive_masked_flag(o_receive_masked_flag));

//--- sim/tb.sv
// self-checking bench for the irq/dma control block
`timescale 1ns/1ps
module tb
    import uisd_pkg::*;
;
    logic clk, rst_b, wr, rd, rx_av, tx_av;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic irq, rx_req, tx_req;
    uisd_src_vec_t fire, evt, mf;
    int n_mismatch = 0, n_tests = 0;
    // expected raw word per source, one row each
    logic [31:0] rows [10] = '{32'h2, 32'h10, 32'h20, 32'h40, 32'h80, 32'h100, 32'h200, 32'h400, 32'h800, 32'h1000};
    uisd_top u_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr_stb(wr),
        .i_rd_stb(rd), .o_rdata(rdata), .i_cts_evt(evt[0]), .i_rx_evt(evt[1]), .i_tx_evt(evt[2]),
        .i_rx_timeout_evt(evt[3]), .i_framing_err_evt(evt[4]), .i_parity_err_evt(evt[5]),
        .i_break_err_evt(evt[6]), .i_overrun_err_evt(evt[7]), .i_flow_stop_evt(evt[8]),
        .i_tx_queue_empty_evt(evt[9]), .i_rx_data_avail(rx_av), .i_tx_space_avail(tx_av), .o_irq(irq),
        .o_rx_dma_req(rx_req), .o_tx_dma_req(tx_req), .o_cts_masked_flag(mf[0]), .o_receive_masked_flag(mf[1]),
        .o_transmit_masked_flag(mf[2]), .o_rx_timeout_masked_flag(mf[3]), .o_framing_err_masked_flag(mf[4]),
        .o_parity_err_masked_flag(mf[5]), .o_break_err_masked_flag(mf[6]), .o_overrun_err_masked_flag(mf[7]),
        .o_flow_stop_masked_flag(mf[8]), .o_tx_queue_empty_masked_flag(mf[9]));
    uisd_evt_model u_evt (.i_core_clk(clk), .i_fire(fire), .o_evt(evt));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wrr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask : wrr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) begin rd <= 1'b1; addr <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask : rdc
    task automatic pulse(input uisd_src_vec_t f);
        @(posedge clk) fire <= f;
        @(posedge clk) fire <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        {rst_b, wr, rd, rx_av, tx_av, addr, wdata, fire} = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 8'h38; a <= 8'h48; a += 4) rdc(a[7:0], 32'h0);
        wrr(8'h38, 32'hffff_ffff);
        rdc(8'h38, 32'h1ff2);
        // one row per source: set, view raw and masked, clear
        for (int i = 0; i < 10; i++) begin
            pulse(uisd_src_vec_t'(1) << i);
            rdc(8'h3c, rows[i]);
            rdc(8'h40, rows[i]);
            chk("mflags", 32'(uisd_src_vec_t'(1) << i), 32'(mf));
            chk("irq", 32'h1, 32'(irq));
            wrr(8'h44, rows[i]);
            rdc(8'h3c, 32'h0);
            chk("irq", 32'h0, 32'(irq));
        end
        // masked off, read-only and write-zero cases
        wrr(8'h38, 32'h0);
        pulse(10'h002);
        rdc(8'h3c, 32'h10);
        rdc(8'h40, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        wrr(8'h44, 32'h0);
        wrr(8'h3c, 32'h0);
        wrr(8'h40, 32'h0);
        rdc(8'h3c, 32'h10);
        rdc(8'h44, 32'h0);
        rdc(8'h7c, 32'h0);
        wrr(8'h38, 32'h10);
        chk("irq", 32'h1, 32'(irq));
        // event in the same cycle as its clear keeps the flag
        @(posedge clk) fire <= 10'h002;
        @(posedge clk) begin fire <= '0; wr <= 1'b1; addr <= 8'h44; wdata <= 32'h10; end
        @(posedge clk) wr <= 1'b0;
        rdc(8'h3c, 32'h10);
        wrr(8'h44, 32'h10);
        // dma enables and halt on masked error
        @(posedge clk) begin rx_av <= 1'b1; tx_av <= 1'b1; end
        wrr(8'h48, 32'hffff_ffff);
        rdc(8'h48, 32'hb);
        chk("dma", 32'h3, {30'h0, tx_req, rx_req});
        wrr(8'h38, 32'h80);
        pulse(10'h010);
        chk("dma", 32'h2, {30'h0, tx_req, rx_req});
        wrr(8'h48, 32'h3);
        chk("dma", 32'h3, {30'h0, tx_req, rx_req});
        @(posedge clk) begin rx_av <= 1'b0; tx_av <= 1'b0; end
        #1 chk("dma", 32'h0, {30'h0, tx_req, rx_req});
        @(posedge clk) begin rx_av <= 1'b1; tx_av <= 1'b1; end
        wrr(8'h48, 32'h0);
        chk("dma", 32'h0, {30'h0, tx_req, rx_req});
        // second reset in mid-run
        wrr(8'h48, 32'h3);
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk("rst", 32'h0, {29'h0, irq, tx_req, rx_req});
        rdc(8'h3c, 32'h0);
        rdc(8'h48, 32'h0);
        print_verdict();
    end
endmodule : tb
